// ### rtl/grip_pkg.sv
// constants for the gripper command interpreter
// assumes a single 125 mhz clock and cyclic process data presented as parallel words
package grip_pkg;
  localparam int CLK_MHZ = 125;
  // command word values
  localparam logic [15:0] CMD_IDLE     = 16'h0000;
  localparam logic [15:0] CMD_TRANSFER = 16'h0001;
  localparam logic [15:0] CMD_OUTWARD  = 16'h0100;
  localparam logic [15:0] CMD_INWARD   = 16'h0200;
  // profile selector values
  localparam logic [7:0] PROF_MOTOR_ON  = 8'h03;
  localparam logic [7:0] PROF_HOME_IN_X = 8'h11;
  // status word bit positions
  localparam int ST_MOTOR   = 1;
  localparam int ST_INMOT   = 2;
  localparam int ST_DONE    = 3;
  localparam int ST_BOOTED  = 6;
  localparam int ST_OUTER   = 8;
  localparam int ST_INNER   = 10;
  localparam int ST_XFER    = 12;
  localparam int ST_DIR_OUT = 13;
  localparam int ST_DIR_IN  = 14;
  localparam int ST_ERR     = 15;
  // fault codes
  localparam logic [15:0] FAULT_NONE   = 16'h0000;
  localparam logic [15:0] FAULT_STROKE = 16'h0001;
  // timing
  localparam int BOOT_NS     = 1000;
  localparam int BOOT_CYCLES = (BOOT_NS * CLK_MHZ + 999) / 1000;
  localparam int STORE_MS    = 2;
  // register bus offsets
  localparam logic [3:0] REG_IRQ_STATUS = 4'h0;
  localparam logic [3:0] REG_IRQ_MASK   = 4'h1;
  localparam logic [3:0] REG_STORED_POS = 4'h2;
  localparam logic [3:0] REG_MAX_STROKE = 4'h3;
  // interrupt status bits
  localparam int IRQ_XFER = 0;
  localparam int IRQ_HOMED = 1;
  localparam int IRQ_ARRIVE = 2;
  localparam int IRQ_N = 3;
  localparam logic [15:0] STROKE_MARGIN = 16'd75;
  localparam logic [15:0] MAX_STROKE_RST = 16'd4000;
endpackage

// ### rtl/gripper_parameter_handshake.sv
// command interpreter: handshake, motor on, moves, inward special homing
// assumes process data words are synchronous to mclk_in; stop and boot pins are asynchronous
module gripper_parameter_handshake
  import grip_pkg::*;
#(
  parameter int POS_W = 16
) (
  // clock and reset
  input  wire logic             mclk_in,
  input  wire logic             nrst_in,
  // process data from controller
  input  wire logic [15:0]      command_word_in,
  input  wire logic [7:0]       profile_selector_in,
  input  wire logic [7:0]       recipe_index_in,
  input  wire logic [POS_W-1:0] position_window_in,
  input  wire logic [7:0]       clamp_force_in,
  input  wire logic [7:0]       travel_speed_in,
  input  wire logic [POS_W-1:0] outer_target_in,
  input  wire logic [POS_W-1:0] speed_change_point_in,
  input  wire logic [POS_W-1:0] learned_target_in,
  input  wire logic [POS_W-1:0] inner_target_in,
  // mechanics and boot pins
  input  wire logic             boot_done_in,
  input  wire logic             hard_stop_in,
  // retained position from non-volatile store
  input  wire logic [POS_W-1:0] retained_pos_in,
  // process data to controller
  output logic [15:0]           status_word_a_out,
  output logic [15:0]           fault_code_word_out,
  output logic [POS_W-1:0]      jaw_position_now_out,
  output logic                  reporting_out,
  // motion and store
  output logic                  motor_drive_out,
  output logic                  move_inward_out,
  output logic [7:0]            speed_out,
  output logic [7:0]            force_out,
  output logic                  store_pos_out,
  // register bus
  input  wire logic [3:0]       reg_addr_in,
  input  wire logic [15:0]      reg_wdata_in,
  input  wire logic             reg_wr_in,
  input  wire logic             reg_rd_in,
  output logic [15:0]           reg_rdata_out,
  output logic                  irq_out
);
  import grip_pkg::*;

  typedef enum logic [2:0] {BOOT, IDLE, ACK, MOVE, HOMING} state_t;
  state_t state;

  logic boot_m, boot_s, stop_m, stop_s;
  logic [15:0] boot_cnt;
  logic booted;
  logic [7:0] prof;
  logic [POS_W-1:0] win, outer_t, inner_t, pos;
  logic motor, dir_in, dir_out, at_inner, at_outer, inmot, done;
  logic [15:0] fault, max_stroke;
  logic [IRQ_N-1:0] irq_st, irq_mask, irq_ev;
  logic was_move;

  // pins cross into mclk domain
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      boot_m <= 1'b0;
      boot_s <= 1'b0;
      stop_m <= 1'b0;
      stop_s <= 1'b0;
    end else begin
      boot_m <= boot_done_in;
      boot_s <= boot_m;
      stop_m <= hard_stop_in;
      stop_s <= stop_m;
    end
  end

  // short settle after boot pin so reported data are valid
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      boot_cnt <= '0;
      booted   <= 1'b0;
    end else if (boot_s && !booted) begin
      boot_cnt <= boot_cnt + 16'd1;
      if (boot_cnt == 16'(BOOT_CYCLES - 1)) begin
        booted <= 1'b1;
      end
    end
  end

  // main sequencer
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state   <= BOOT;
      prof    <= '0;
      win     <= '0;
      outer_t <= '0;
      inner_t <= '0;
      pos     <= '0;
      motor   <= 1'b0;
      dir_in  <= 1'b0;
      dir_out <= 1'b0;
      inmot   <= 1'b0;
      done    <= 1'b0;
      fault   <= FAULT_NONE;
    end else begin
      unique case (state)
        BOOT: begin
          if (booted) begin
            pos   <= retained_pos_in;
            state <= IDLE;
          end
        end
        IDLE: begin
          if (command_word_in == CMD_TRANSFER) begin
            // recipe index not decoded: take presented values as they stand for every recipe
            prof    <= profile_selector_in;
            win     <= position_window_in;
            outer_t <= outer_target_in;
            inner_t <= inner_target_in;
            inmot   <= 1'b0;
            state   <= ACK;
            if (profile_selector_in == PROF_MOTOR_ON) begin
              motor <= 1'b1;
              fault <= FAULT_NONE;
            end else if (profile_selector_in == PROF_HOME_IN_X) begin
              if (inner_target_in > max_stroke + STROKE_MARGIN) begin
                fault <= FAULT_STROKE;
              end else begin
                inmot <= 1'b1;
              end
            end
          end else if (command_word_in == CMD_INWARD && motor && !dir_in) begin
            dir_in  <= 1'b1;
            dir_out <= 1'b0;
            inmot   <= 1'b1;
            done    <= 1'b0;
            state   <= MOVE;
          end else if (command_word_in == CMD_OUTWARD && motor && !dir_out) begin
            dir_out <= 1'b1;
            dir_in  <= 1'b0;
            inmot   <= 1'b1;
            done    <= 1'b0;
            state   <= MOVE;
          end
        end
        ACK: begin
          if (command_word_in == CMD_IDLE) begin
            state <= inmot ? HOMING : IDLE;
          end
        end
        MOVE: begin
          // one position step per cycle; order drops if command released early
          if (command_word_in != (dir_in ? CMD_INWARD : CMD_OUTWARD)) begin
            inmot <= 1'b0;
            state <= IDLE;
          end else if (dir_in ? (pos >= inner_t) : (pos <= outer_t)) begin
            inmot <= 1'b0;
            done  <= 1'b1;
            state <= IDLE;
          end else begin
            pos <= dir_in ? pos + POS_W'(1) : pos - POS_W'(1);
          end
        end
        HOMING: begin
          if (stop_s) begin
            pos   <= inner_t;
            motor <= 1'b0;
            inmot <= 1'b0;
            done  <= 1'b1;
            state <= IDLE;
          end
        end
        default: state <= IDLE;
      endcase
    end
  end

  // position flags use the transferred window
  always_comb begin
    at_inner = (pos + win >= inner_t) && (pos <= inner_t + win);
    at_outer = (pos + win >= outer_t) && (pos <= outer_t + win);
  end

  // registered process data outputs
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      status_word_a_out    <= '0;
      fault_code_word_out  <= FAULT_NONE;
      jaw_position_now_out <= '0;
      reporting_out        <= 1'b0;
      motor_drive_out      <= 1'b0;
      move_inward_out      <= 1'b0;
      speed_out            <= '0;
      force_out            <= '0;
    end else begin
      reporting_out        <= (state != BOOT);
      jaw_position_now_out <= pos;
      fault_code_word_out  <= fault;
      status_word_a_out    <= '0;
      status_word_a_out[ST_BOOTED]  <= (state != BOOT);
      status_word_a_out[ST_MOTOR]   <= motor;
      status_word_a_out[ST_INMOT]   <= inmot;
      status_word_a_out[ST_DONE]    <= done;
      status_word_a_out[ST_OUTER]   <= at_outer;
      status_word_a_out[ST_INNER]   <= at_inner;
      status_word_a_out[ST_XFER]    <= (state == ACK);
      status_word_a_out[ST_DIR_OUT] <= dir_out;
      status_word_a_out[ST_DIR_IN]  <= dir_in;
      status_word_a_out[ST_ERR]     <= (fault != FAULT_NONE);
      motor_drive_out      <= motor && (state == MOVE || state == HOMING);
      move_inward_out      <= (state == HOMING) || (state == MOVE && dir_in);
      speed_out            <= travel_speed_in;
      force_out            <= clamp_force_in;
    end
  end

  // each completed handshake stores position for power-down
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      store_pos_out <= 1'b0;
      was_move      <= 1'b0;
    end else begin
      store_pos_out <= (state == ACK) && (command_word_in == CMD_IDLE);
      was_move      <= (state == MOVE);
    end
  end

  // interrupt events
  always_comb begin
    irq_ev = '0;
    irq_ev[IRQ_XFER]   = (state == IDLE) && (command_word_in == CMD_TRANSFER);
    irq_ev[IRQ_HOMED]  = (state == HOMING) && stop_s;
    irq_ev[IRQ_ARRIVE] = was_move && (state == IDLE) && done;
  end

  // status sticky, write one to clear, set wins
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_st     <= '0;
      irq_mask   <= '0;
      max_stroke <= MAX_STROKE_RST;
      irq_out    <= 1'b0;
    end else begin
      if (reg_wr_in && reg_addr_in == REG_IRQ_STATUS) begin
        irq_st <= (irq_st & ~reg_wdata_in[IRQ_N-1:0]) | irq_ev;
      end else begin
        irq_st <= irq_st | irq_ev;
      end
      if (reg_wr_in && reg_addr_in == REG_IRQ_MASK) begin
        irq_mask <= reg_wdata_in[IRQ_N-1:0];
      end
      if (reg_wr_in && reg_addr_in == REG_MAX_STROKE) begin
        max_stroke <= reg_wdata_in;
      end
      irq_out <= |(irq_st & irq_mask);
    end
  end

  // read data one cycle after strobe; unmapped reads zero
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reg_rdata_out <= '0;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        REG_IRQ_STATUS: reg_rdata_out <= 16'(irq_st);
        REG_IRQ_MASK:   reg_rdata_out <= 16'(irq_mask);
        REG_STORED_POS: reg_rdata_out <= 16'(pos);
        REG_MAX_STROKE: reg_rdata_out <= max_stroke;
        default:        reg_rdata_out <= '0;
      endcase
    end else begin
      reg_rdata_out <= '0;
    end
  end

  AST_ACK_RISES: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (state == IDLE && command_word_in == CMD_TRANSFER) |-> ##2 status_word_a_out[ST_XFER])
    else $error("acknowledge did not rise two cycles after transfer");
  AST_ACK_DROPS: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (state == ACK && command_word_in == CMD_IDLE) |-> ##2 !status_word_a_out[ST_XFER])
    else $error("acknowledge did not drop after command zero");
  AST_MOTOR_ON: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (state == IDLE && command_word_in == CMD_TRANSFER && profile_selector_in == PROF_MOTOR_ON)
    |-> ##2 status_word_a_out[ST_MOTOR])
    else $error("motor not reported on");
  AST_HOME_LOAD: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (state == HOMING && stop_s) |-> ##2 (jaw_position_now_out == $past(inner_t, 2)))
    else $error("homing did not load inner target");
  AST_HOME_OFF: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (state == HOMING && stop_s) |=> !motor)
    else $error("motor still on after homing");
  AST_BOOT_BIT: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (state == BOOT) |=> !status_word_a_out[ST_BOOTED])
    else $error("booted reported before boot");
  AST_READY_FAULT: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (state == IDLE && command_word_in == CMD_TRANSFER && profile_selector_in == PROF_MOTOR_ON)
    |-> ##2 (fault_code_word_out == FAULT_NONE))
    else $error("fault not cleared when ready");
  AST_RETAIN: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (state == BOOT && booted) |=> (pos == $past(retained_pos_in)))
    else $error("retained position not restored");
  AST_INWARD: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (state == MOVE && dir_in && command_word_in == CMD_INWARD && pos < inner_t)
    |=> (pos == $past(pos) + POS_W'(1)))
    else $error("inward move did not advance");
  AST_TAKE_PARAMS: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (state == IDLE && command_word_in == CMD_TRANSFER)
    |=> (inner_t == $past(inner_target_in) && outer_t == $past(outer_target_in)))
    else $error("presented parameters not taken");
  AST_STROKE_FAULT: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (state == IDLE && command_word_in == CMD_TRANSFER && profile_selector_in == PROF_HOME_IN_X
     && inner_target_in > max_stroke + STROKE_MARGIN) |=> (fault == FAULT_STROKE && !inmot))
    else $error("over-stroke target not refused");
  AST_ACK_HOLDS: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (state == ACK && command_word_in != CMD_IDLE) |=> (state == ACK))
    else $error("acknowledge left before command returned to zero");
  AST_NO_MOVE_OFF: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (state == IDLE && !motor) |=> (state != MOVE))
    else $error("move started with motor off");
  AST_MOVE_HELD: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (state == MOVE && command_word_in == CMD_IDLE) |=> (state == IDLE && !inmot))
    else $error("move continued after command released");
  AST_OUTWARD: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (state == MOVE && dir_out && command_word_in == CMD_OUTWARD && pos > outer_t)
    |=> (pos == $past(pos) - POS_W'(1)))
    else $error("outward move did not retreat");
  AST_REPORTING: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (state != BOOT) |=> reporting_out)
    else $error("reporting missing after boot");
endmodule

// ### dv/plc_master.sv
// controller model: presents process data and runs the handshake
// assumes the device status word on the same clock; the bench calls its tasks
module plc_master
  import grip_pkg::*;
(
  // clock and status
  input  wire logic        mclk_in,
  input  wire logic [15:0] status_in,
  // process data out
  output logic [15:0]      cmd_out,
  output logic [7:0]       prof_out,
  output logic [7:0]       recipe_out,
  output logic [7:0]       speed_out,
  output logic [7:0]       force_out,
  output logic [15:0]      window_out,
  output logic [15:0]      outer_out,
  output logic [15:0]      shift_out,
  output logic [15:0]      learn_out,
  output logic [15:0]      inner_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // full set always presented
  initial begin
    cmd_out = CMD_IDLE;
    prof_out = 8'h00;
    recipe_out = 8'h00;
    speed_out = 8'h0a;
    force_out = 8'h32;
    window_out = 16'h0032;
    outer_out = 16'h0064;
    shift_out = 16'h07d0;
    learn_out = 16'h0fa0;
    inner_out = 16'h0fa0;
  end
  task automatic wait_st(input int b, input logic v, output logic hit);
    hit = 1'b0;
    for (int i = 0; i < 400 && !hit; i++) begin
      @(posedge mclk_in);
      hit = (status_in[b] === v);
    end
  endtask
  // close after the acknowledge, next request after it drops; each wait gives up after 400 cycles
  task automatic xfer(input logic [7:0] prof, input logic [7:0] spd,
                      input logic [15:0] inner, output logic ok);
    logic hit;
    prof_out <= prof;
    speed_out <= spd;
    inner_out <= inner;
    cmd_out <= CMD_TRANSFER;
    wait_st(ST_XFER, 1'b1, hit);
    ok = hit;
    cmd_out <= CMD_IDLE;
    wait_st(ST_XFER, 1'b0, hit);
    ok = ok & hit;
  endtask
  task automatic move(input logic [15:0] dir, input int n);
    cmd_out <= dir;
    repeat (n) @(posedge mclk_in);
    cmd_out <= CMD_IDLE;
  endtask
endmodule

// ### dv/tb.sv
// bench for the gripper command interpreter
// assumes plc_master as controller; boot, stop and retained position pins driven here, store pin answered here
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import grip_pkg::*;
  logic        mclk_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic        boot_done_in = 1'b0;
  logic        hard_stop_in = 1'b0;
  logic [15:0] retained_pos_in = 16'h0000;
  logic [3:0]  reg_addr_in = 4'h0;
  logic [15:0] reg_wdata_in = 16'h0000;
  logic        reg_wr_in = 1'b0;
  logic        reg_rd_in = 1'b0;
  logic [15:0] cmd, win, outer, shift, learn, inner, status, fault, pos, rdata, nv;
  logic [7:0]  prof, recipe, spd, frc, spd_o, frc_o;
  logic        reporting, motor, inward, store, irq, ok;
  int          error_cnt = 0;
  int          total_checks = 0;
  always #4 mclk_in = ~mclk_in;
  // stand-in for the non-volatile store
  always @(posedge mclk_in) if (store === 1'b1) nv <= pos;
  plc_master plc (.mclk_in(mclk_in), .status_in(status), .cmd_out(cmd), .prof_out(prof),
    .recipe_out(recipe), .speed_out(spd), .force_out(frc), .window_out(win),
    .outer_out(outer), .shift_out(shift), .learn_out(learn), .inner_out(inner));
  gripper_parameter_handshake dut (.mclk_in(mclk_in), .nrst_in(nrst_in),
    .command_word_in(cmd), .profile_selector_in(prof), .recipe_index_in(recipe),
    .position_window_in(win), .clamp_force_in(frc), .travel_speed_in(spd),
    .outer_target_in(outer), .speed_change_point_in(shift), .learned_target_in(learn),
    .inner_target_in(inner), .boot_done_in(boot_done_in), .hard_stop_in(hard_stop_in),
    .retained_pos_in(retained_pos_in), .status_word_a_out(status),
    .fault_code_word_out(fault), .jaw_position_now_out(pos), .reporting_out(reporting),
    .motor_drive_out(motor), .move_inward_out(inward), .speed_out(spd_o),
    .force_out(frc_o), .store_pos_out(store), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(rdata), .irq_out(irq));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp, input string what);
    chk({15'h0, got}, {15'h0, exp}, what);
  endtask
  task automatic end_of_test();
    if (error_cnt == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // slow enough for irq, which trails status by a cycle
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
  endtask
  task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge mclk_in);
    reg_rd_in <= 1'b0;
    @(posedge mclk_in);
    d = rdata;
  endtask
  task automatic boot(input logic [15:0] keep);
    nrst_in <= 1'b0;
    boot_done_in <= 1'b0;
    retained_pos_in <= keep;
    repeat (6) @(posedge mclk_in);
    chk(status, 16'h0000, "status in reset");
    nrst_in <= 1'b1;
    boot_done_in <= 1'b1;
    plc.wait_st(ST_BOOTED, 1'b1, ok);
    chk1(ok, 1'b1, "booted bit");
    #1 chk1(reporting, 1'b1, "reporting");
    chk(pos, keep, "position at boot");
    chk(fault, FAULT_NONE, "fault at boot");
  endtask
  task automatic motor_on();
    @(posedge mclk_in);
    plc.xfer(PROF_MOTOR_ON, 8'h0a, 16'h0fa0, ok);
    #1 chk1(ok, 1'b1, "handshake");
    chk1(status[ST_MOTOR], 1'b1, "motor bit");
    chk1(motor, 1'b0, "drive idle while not moving");
  endtask
  task automatic moves();
    logic [15:0] p0;
    @(posedge mclk_in);
    p0 = pos;
    plc.move(CMD_INWARD, 20);
    #1 chk1(inward, 1'b1, "moving in");
    chk1(motor, 1'b1, "drive moving");
    repeat (3) @(posedge mclk_in);
    #1 chk1(pos > p0, 1'b1, "jaws in");
    chk1(status[ST_DIR_IN], 1'b1, "in flag");
    @(posedge mclk_in);
    p0 = pos;
    plc.move(CMD_OUTWARD, 20);
    repeat (3) @(posedge mclk_in);
    #1 chk1(pos < p0, 1'b1, "jaws out");
    chk1(status[ST_DIR_OUT], 1'b1, "out flag");
  endtask
  task automatic recipe_zero();
    @(posedge mclk_in);
    plc.xfer(8'h59, 8'h21, 16'h0fa0, ok);
    #1 chk({spd_o, frc_o}, 16'h2132, "presented values");
  endtask
  // over-stroke target first, then a proper run against the stop
  task automatic homing();
    motor_on();
    @(posedge mclk_in);
    plc.xfer(PROF_HOME_IN_X, 8'h0a, MAX_STROKE_RST + STROKE_MARGIN + 16'h0001, ok);
    #1 chk(fault, FAULT_STROKE, "stroke limit");
    chk1(inward, 1'b0, "no homing");
    @(posedge mclk_in);
    plc.xfer(PROF_HOME_IN_X, 8'h0a, 16'h0fa0, ok);
    repeat (20) @(posedge mclk_in);
    chk1(inward, 1'b1, "homing in");
    hard_stop_in <= 1'b1;
    for (int i = 0; i < 50 && motor !== 1'b0; i++)
      @(posedge mclk_in);
    chk(pos, 16'h0fa0, "homed position");
    chk1(status[ST_MOTOR], 1'b0, "motor off");
    hard_stop_in <= 1'b0;
    motor_on();
    chk(fault, FAULT_NONE, "ready");
  endtask
  task automatic regs();
    logic [15:0] d;
    @(posedge mclk_in);
    reg_rd(REG_MAX_STROKE, d);
    chk(d, MAX_STROKE_RST, "stroke reset");
    reg_rd(REG_STORED_POS, d);
    chk(d, 16'h0fa0, "position reg");
    reg_rd(4'hf, d);
    chk(d, 16'h0000, "unmapped");
    reg_wr(REG_MAX_STROKE, 16'h1234);
    reg_rd(REG_MAX_STROKE, d);
    chk(d, 16'h1234, "stroke write");
    reg_wr(REG_MAX_STROKE, MAX_STROKE_RST);
    reg_rd(REG_IRQ_STATUS, d);
    chk(d & 16'h0003, 16'h0003, "events");
    // mask bit set enables the source
    reg_wr(REG_IRQ_MASK, 16'h0000);
    chk1(irq, 1'b0, "masked");
    reg_wr(REG_IRQ_MASK, 16'h0007);
    chk1(irq, 1'b1, "unmasked");
    reg_wr(REG_IRQ_STATUS, 16'h0007);
    chk1(irq, 1'b0, "cleared");
    reg_rd(REG_IRQ_STATUS, d);
    chk(d, 16'h0000, "status cleared");
  endtask
  // handshake before power off, then a cold restart
  task automatic restart();
    @(posedge mclk_in);
    plc.xfer(PROF_MOTOR_ON, 8'h0a, 16'h0fa0, ok);
    repeat (4) @(posedge mclk_in);
    chk(nv, 16'h0fa0, "stored position");
    boot(nv);
  endtask
  initial begin
    boot(16'h0123);
    motor_on();
    moves();
    recipe_zero();
    homing();
    regs();
    restart();
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge mclk_in);
    error_cnt++;
    end_of_test();
  end
endmodule
